// ### core/flcrm_top.sv
// Purpose: Flash mode control, error status and erase block select registers
// Assumes: Avalon-MM slave with waitrequest, one clock, asynchronous reset
// Notes:   Every access waits one cycle; read data registered
//
// Overview of operation
// - Mode control byte: write gate, soft gate, setups, verifies, runs, high to low.
// - Error status at next index carries the fault flag in bit 7, rest reserved.
// - Block select serves erase only, exactly one block; programming needs none.
// - Eight erase blocks: four of 1 kbyte, one 28 kbyte, three 32 kbyte.
// - Blocks ascend from block zero; the last large block ends at the top.
//
// Local design decision: the Avalon-MM register port.
module flcrm_top
    import flcrm_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Write gate pin
    input  wire logic              flash_write_gate_pin,
    // Flash array control
    output flcrm_mode_t            mode_out,
    output flcrm_window_t          erase_window,
    output logic                   flash_fault_flag,
    output logic [7:0]             ram_emulation_out,
    // Interrupt
    output logic                   irq
);

    // Registers
    flcrm_mode_t   mode_q;
    flcrm_mode_t   mode_d;
    logic [7:0]    block_sel_q;
    logic [7:0]    block_sel_d;
    logic [7:0]    ram_emu_q;
    logic [7:0]    ram_emu_d;
    logic          fault_q;
    logic          fault_d;
    logic [7:0]    irq_status_q;
    logic [7:0]    irq_status_d;
    logic [7:0]    irq_mask_q;
    logic [7:0]    irq_mask_d;
    logic          ack_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          gate_prev_q;

    // Bus decode
    wire           req         = avs_read | avs_write;
    wire           lane0       = avs_byteenable[0];
    wire           aligned     = (avs_address[1:0] == 2'b00);
    wire [15:0]    idx         = 16'(avs_address[ADDR_W-1:2]);
    wire           take        = req & ~ack_q;
    wire           wr_take     = take & avs_write & aligned & lane0;
    wire           rd_take     = take & avs_read;
    wire           hit_mode    = aligned & (idx == IDX_MODE_CTRL);
    wire           hit_err     = aligned & (idx == IDX_ERR_STATUS);
    wire           hit_blk     = aligned & (idx == IDX_BLOCK_SEL);
    wire           hit_ram     = aligned & (idx == IDX_RAM_EMU);
    wire           hit_ist     = aligned & (idx == IDX_IRQ_STATUS);
    wire           hit_imsk    = aligned & (idx == IDX_IRQ_MASK);
    wire           wr_mode     = wr_take & hit_mode;
    wire           wr_blk      = wr_take & hit_blk;
    wire           wr_ram      = wr_take & hit_ram;
    wire           wr_ist      = wr_take & hit_ist;
    wire           wr_imsk     = wr_take & hit_imsk;
    wire [7:0]     wbyte       = avs_writedata[7:0];

    // Synchronised write gate pin
    logic          gate_sync;

    flcrm_sync2 u_gate_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in (flash_write_gate_pin),
        .sync_out (gate_sync)
    );

    // Erase window decode from the current block select
    flcrm_window_t window_w;

    flcrm_block_map u_block_map (
        .block_sel (block_sel_q),
        .window    (window_w)
    );

    // Requested mode byte from a write
    flcrm_mode_t   req_mode;
    assign req_mode = flcrm_mode_t'(wbyte);

    // Setup, verify and run bits only stick while both gates are open
    wire           gates_open  = gate_sync & req_mode.software_write_gate;
    wire           erase_busy  = mode_q.erase_setup | mode_q.erase_run;

    // Illegal requests that raise the fault flag
    wire           bad_erase   = req_mode.erase_run
                                 & (~window_w.valid | ~mode_q.erase_setup);
    wire           bad_prog    = req_mode.program_run & ~mode_q.program_setup;
    wire           bad_both    = (req_mode.erase_setup & req_mode.program_setup)
                                 | (req_mode.erase_run & req_mode.program_run);
    wire           bad_gate    = (req_mode.erase_run | req_mode.program_run)
                                 & ~gates_open;
    wire           fault_event = wr_mode & (bad_erase | bad_prog | bad_both | bad_gate);

    // Gate loss forces the array back to read
    wire           gate_fell   = gate_prev_q & ~gate_sync;
    wire           erase_start = wr_mode & ~fault_event & req_mode.erase_run
                                 & ~mode_q.erase_run;
    wire           prog_start  = wr_mode & ~fault_event & req_mode.program_run
                                 & ~mode_q.program_run;

    // Mode control next state
    always_comb begin
        mode_d            = mode_q;
        mode_d.write_gate = gate_sync;
        if (wr_mode) begin
            mode_d.software_write_gate = req_mode.software_write_gate;
            if (gates_open && !fault_event && !fault_q) begin
                mode_d.erase_setup    = req_mode.erase_setup;
                mode_d.program_setup  = req_mode.program_setup;
                mode_d.erase_verify   = req_mode.erase_verify;
                mode_d.program_verify = req_mode.program_verify;
                mode_d.erase_run      = req_mode.erase_run;
                mode_d.program_run    = req_mode.program_run;
            end else begin
                mode_d.erase_setup    = 1'b0;
                mode_d.program_setup  = 1'b0;
                mode_d.erase_verify   = 1'b0;
                mode_d.program_verify = 1'b0;
                mode_d.erase_run      = 1'b0;
                mode_d.program_run    = 1'b0;
            end
        end
        if (!gate_sync || fault_q) begin
            mode_d.erase_setup    = 1'b0;
            mode_d.program_setup  = 1'b0;
            mode_d.erase_verify   = 1'b0;
            mode_d.program_verify = 1'b0;
            mode_d.erase_run      = 1'b0;
            mode_d.program_run    = 1'b0;
        end
    end

    // Block select holds while an erase is set up or running
    assign block_sel_d = (wr_blk && !erase_busy) ? wbyte : block_sel_q;

    // Fault flag: set by hardware only, cleared by reset only
    assign fault_d     = fault_q | fault_event;

    // RAM emulation control
    assign ram_emu_d   = wr_ram ? (wbyte & RAM_EMU_MASK) : ram_emu_q;

    // Interrupt status: set wins over a write-one clear
    logic [7:0]    irq_events;
    always_comb begin
        irq_events                = 8'h00;
        irq_events[IRQ_FAULT_BIT] = fault_event;
        irq_events[IRQ_ERASE_BIT] = erase_start;
        irq_events[IRQ_PROG_BIT]  = prog_start;
        irq_events[IRQ_GATE_BIT]  = gate_fell;
    end

    wire [7:0]     ist_clear   = wr_ist ? wbyte : 8'h00;
    assign irq_status_d = ((irq_status_q & ~ist_clear) | irq_events) & IRQ_IMPL_MASK;
    assign irq_mask_d   = wr_imsk ? (wbyte & IRQ_IMPL_MASK) : irq_mask_q;

    // Error status read value, reserved bits read zero
    logic [7:0]    err_byte;
    always_comb begin
        err_byte                = 8'h00;
        err_byte[ERR_FAULT_BIT] = fault_q;
    end

    // Read data mux, unmapped reads return zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_mode) begin
            rdata_d[7:0] = mode_q;
        end else if (hit_err) begin
            rdata_d[7:0] = err_byte;
        end else if (hit_blk) begin
            rdata_d[7:0] = block_sel_q;
        end else if (hit_ram) begin
            rdata_d[7:0] = ram_emu_q;
        end else if (hit_ist) begin
            rdata_d[7:0] = irq_status_q;
        end else if (hit_imsk) begin
            rdata_d[7:0] = irq_mask_q;
        end
    end

    // Bus handshake: wait one cycle, answer on the second
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= take;
            if (rd_take) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Register state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q       <= flcrm_mode_t'(RST_MODE_CTRL);
            block_sel_q  <= RST_BLOCK_SEL;
            ram_emu_q    <= RST_RAM_EMU;
            fault_q      <= 1'b0;
            irq_status_q <= RST_IRQ;
            irq_mask_q   <= RST_IRQ;
            gate_prev_q  <= 1'b0;
        end else begin
            mode_q       <= mode_d;
            block_sel_q  <= block_sel_d;
            ram_emu_q    <= ram_emu_d;
            fault_q      <= fault_d;
            irq_status_q <= irq_status_d;
            irq_mask_q   <= irq_mask_d;
            gate_prev_q  <= gate_sync;
        end
    end

    // Outputs
    assign avs_waitrequest   = req & ~ack_q;
    assign avs_readdata      = rdata_q;
    assign mode_out          = mode_q;
    assign flash_fault_flag  = fault_q;
    assign ram_emulation_out = ram_emu_q;
    assign irq               = |(irq_status_q & irq_mask_q);

    // Erase window shown only for a legal single-block selection
    always_comb begin
        erase_window       = window_w;
        erase_window.valid = window_w.valid & erase_busy;
    end

endmodule : flcrm_top

// ### core/flcrm_pkg.sv
// Purpose: Shared constants, types and functions for the flash control register block
// Assumes: 8-bit registers, each on its own 32-bit Avalon word
// Notes:   Byte address of a register is four times its index
package flcrm_pkg;

    // Register indices; byte address is index * 4
    localparam logic [15:0] IDX_MODE_CTRL   = 16'hFF40;
    localparam logic [15:0] IDX_ERR_STATUS  = 16'hFF41;
    localparam logic [15:0] IDX_BLOCK_SEL   = 16'hFF42;
    localparam logic [15:0] IDX_RAM_EMU     = 16'hFF47;
    localparam logic [15:0] IDX_IRQ_STATUS  = 16'hFF48;
    localparam logic [15:0] IDX_IRQ_MASK    = 16'hFF49;

    // Reset values
    localparam logic [7:0]  RST_MODE_CTRL   = 8'h00;
    localparam logic [7:0]  RST_BLOCK_SEL   = 8'h00;
    localparam logic [7:0]  RST_RAM_EMU     = 8'h00;
    localparam logic [7:0]  RST_IRQ         = 8'h00;

    // Error status field positions
    localparam int          ERR_FAULT_BIT   = 7;

    // Interrupt status / mask field positions
    localparam int          IRQ_FAULT_BIT   = 0;
    localparam int          IRQ_ERASE_BIT   = 1;
    localparam int          IRQ_PROG_BIT    = 2;
    localparam int          IRQ_GATE_BIT    = 3;
    localparam logic [7:0]  IRQ_IMPL_MASK   = 8'h0F;

    // RAM emulation field layout
    localparam int          RAM_EMU_EN_BIT  = 3;
    localparam logic [7:0]  RAM_EMU_MASK    = 8'h0F;

    // Flash array geometry: eight erase blocks, ascending addresses
    localparam int          FLASH_AW        = 17;
    localparam int          NUM_BLOCKS      = 8;
    localparam logic [FLASH_AW-1:0] BLK_SIZE_SMALL = 17'h00400;
    localparam logic [FLASH_AW-1:0] BLK_SIZE_MID   = 17'h07000;
    localparam logic [FLASH_AW-1:0] BLK_SIZE_LARGE = 17'h08000;
    localparam logic [FLASH_AW-1:0] FLASH_TOP      = 17'h1FFFF;

    // Mode control register layout, most significant bit first
    typedef struct packed {
        logic write_gate;
        logic software_write_gate;
        logic erase_setup;
        logic program_setup;
        logic erase_verify;
        logic program_verify;
        logic erase_run;
        logic program_run;
    } flcrm_mode_t;

    // Selected erase window
    typedef struct packed {
        logic                valid;
        logic [2:0]          index;
        logic [FLASH_AW-1:0] base;
        logic [FLASH_AW-1:0] last;
    } flcrm_window_t;

    // True when exactly one bit of a block select byte is set
    function automatic logic flcrm_one_hot(input logic [7:0] sel);
        return (sel != 8'h00) && ((sel & (sel - 8'h01)) == 8'h00);
    endfunction : flcrm_one_hot

endpackage : flcrm_pkg

// ### core/flcrm_sync2.sv
// Purpose: Two flip-flop synchroniser for a level from a pin
// Assumes: Input is asynchronous to clk_sys
// Notes:   First stage is read by the second stage only
module flcrm_sync2 (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : flcrm_sync2

// ### core/flcrm_block_map.sv
// Purpose: Maps a one-hot erase block select byte onto an address window
// Assumes: Blocks ascend from block 0 at address zero
// Notes:   Window is invalid unless exactly one block is chosen
module flcrm_block_map
    import flcrm_pkg::*;
(
    // Block select in
    input  wire logic [7:0]  block_sel,
    // Window out
    output flcrm_window_t    window
);

    logic [FLASH_AW-1:0] base_tab [NUM_BLOCKS];
    logic [FLASH_AW-1:0] size_tab [NUM_BLOCKS];
    logic [2:0]          idx;

    // Four small blocks, one mid block, three large blocks ending at the top
    always_comb begin
        size_tab[0] = BLK_SIZE_SMALL;
        size_tab[1] = BLK_SIZE_SMALL;
        size_tab[2] = BLK_SIZE_SMALL;
        size_tab[3] = BLK_SIZE_SMALL;
        size_tab[4] = BLK_SIZE_MID;
        size_tab[5] = BLK_SIZE_LARGE;
        size_tab[6] = BLK_SIZE_LARGE;
        size_tab[7] = BLK_SIZE_LARGE;
        base_tab[0] = '0;
        for (int i = 1; i < NUM_BLOCKS; i++) begin
            base_tab[i] = base_tab[i-1] + size_tab[i-1];
        end
    end

    // Index of the highest set bit
    always_comb begin
        idx = 3'h0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            if (block_sel[i]) begin
                idx = 3'(i);
            end
        end
    end

    assign window.valid = flcrm_one_hot(block_sel);
    assign window.index = idx;
    assign window.base  = base_tab[idx];
    assign window.last  = base_tab[idx] + size_tab[idx] - 17'h00001;

endmodule : flcrm_block_map

// ### sim/flcrm_top_sva.sv
// Purpose: Concurrent checks on the flash control register block ports
// Assumes: One clock domain, asynchronous active low reset
// Notes:   Attached to flcrm_top by bind at the foot of this file
module flcrm_top_sva
    import flcrm_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              reset_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // Pin and flash control
    input wire logic              flash_write_gate_pin,
    input wire flcrm_mode_t       mode_out,
    input wire flcrm_window_t     erase_window,
    input wire logic              flash_fault_flag,
    input wire logic [7:0]        ram_emulation_out,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Expected window geometry for the selected index
    wire logic [16:0] idx_ext  = {14'h0000, erase_window.index};
    wire logic [16:0] exp_size = (erase_window.index < 3'h4) ? 17'h00400 :
                                 (erase_window.index == 3'h4) ? 17'h07000 : 17'h08000;
    wire logic [16:0] exp_base = (erase_window.index < 3'h4) ? idx_ext * 17'h00400 :
                                 (erase_window.index == 3'h4) ? 17'h01000 :
                                 (idx_ext - 17'h00004) * 17'h08000;

    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait state longer than one cycle");
    a_soft_gate_needed: assert property (mode_out[5:0] != 6'h00
        |-> mode_out.software_write_gate) else $error("mode bits set without soft gate");
    a_setups_exclusive: assert property (!(mode_out.erase_setup && mode_out.program_setup)
        && !(mode_out.erase_run && mode_out.program_run)) else $error("both setups or runs");
    a_fault_blocks_mode: assert property (flash_fault_flag |-> mode_out[5:0] == 6'h00)
        else $error("mode bits set while fault flag high");
    a_fault_sticky: assert property (flash_fault_flag |=> flash_fault_flag)
        else $error("fault flag cleared without reset");
    a_window_erase_only: assert property (erase_window.valid
        |-> (mode_out.erase_setup || mode_out.erase_run)) else $error("window valid idle");
    a_window_size: assert property (erase_window.last == erase_window.base + exp_size - 17'h1)
        else $error("erase block size wrong");
    a_window_base: assert property (erase_window.base == exp_base)
        else $error("erase block base wrong");
    a_select_frozen: assert property (erase_window.valid && $past(erase_window.valid)
        |-> $stable(erase_window.index)) else $error("block select changed during erase");

    cover property (erase_window.valid && erase_window.index == 3'h7);
    cover property ($rose(flash_fault_flag));
    cover property ($rose(irq));

endmodule : flcrm_top_sva

bind flcrm_top flcrm_top_sva #(.ADDR_W(ADDR_W)) u_flcrm_top_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_write_gate_pin(flash_write_gate_pin), .mode_out(mode_out),
    .erase_window(erase_window), .flash_fault_flag(flash_fault_flag),
    .ram_emulation_out(ram_emulation_out), .irq(irq)
);

// ### sim/flcrm_tb_top.sv
// Purpose: Self-checking bench for the flash control register block
// Assumes: Avalon-MM master tasks, one wait state answered by the block
// Notes:   Pin gate, block select sweep, fault, interrupt and reset with the fault flag set
module flcrm_tb_top
    import flcrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Design signals
    logic          clk_sys;
    logic          reset_n;
    logic [17:0]   avs_address;
    logic          avs_read;
    logic          avs_write;
    logic [31:0]   avs_writedata;
    logic [3:0]    avs_byteenable;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    logic          flash_write_gate_pin;
    flcrm_mode_t   mode_out;
    flcrm_window_t erase_window;
    logic          flash_fault_flag;
    logic [7:0]    ram_emulation_out;
    logic          irq;
    int            err_count;
    int            checks_done;
    int            cycles;
    logic [16:0]   base;
    logic [16:0]   size;

    flcrm_top #(.ADDR_W(18)) u_flcrm_top (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flash_write_gate_pin(flash_write_gate_pin),
        .mode_out(mode_out), .erase_window(erase_window),
        .flash_fault_flag(flash_fault_flag), .ram_emulation_out(ram_emulation_out),
        .irq(irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // One bus transfer; request held up to the rising edge that samples waitrequest low
    task automatic bus_op(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                          output logic [31:0] q);
        avs_address   <= {idx, 2'b00};
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h000000, d};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_op

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus_op(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input string name, input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus_op(1'b0, idx, 8'h00, q);
        chk(name, {24'h000000, exp}, q);
    endtask : rd

    initial begin
        reset_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = '0; avs_byteenable = 4'hF; flash_write_gate_pin = 1'b0;
        err_count = 0; checks_done = 0; cycles = 0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd("mode", IDX_MODE_CTRL, 8'h00);
        rd("error", IDX_ERR_STATUS, 8'h00);
        rd("select", IDX_BLOCK_SEL, 8'h00);
        rd("ram_emu", IDX_RAM_EMU, 8'h00);
        chk("window_last", 32'h000003FF, {15'h0, erase_window.last});
        wr(16'hFF50, 8'hFF);
        rd("unmapped", 16'hFF50, 8'h00);
        wr(IDX_RAM_EMU, 8'hFF);
        rd("ram_emu", IDX_RAM_EMU, 8'h0F);
        chk("ram_emu_out", 32'h0000000F, {24'h0, ram_emulation_out});
        avs_byteenable <= 4'hE;
        wr(IDX_RAM_EMU, 8'h00);
        avs_byteenable <= 4'hF;
        rd("ram_emu_lane", IDX_RAM_EMU, 8'h0F);
        wr(IDX_MODE_CTRL, 8'h60);
        rd("mode_no_pin", IDX_MODE_CTRL, 8'h40);
        flash_write_gate_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd("mode_pin", IDX_MODE_CTRL, 8'hC0);
        wr(IDX_MODE_CTRL, 8'h50);
        rd("program_setup", IDX_MODE_CTRL, 8'hD0);
        wr(IDX_MODE_CTRL, 8'h51);
        rd("program_run", IDX_MODE_CTRL, 8'hD1);
        rd("irq_prog", IDX_IRQ_STATUS, 8'h04);
        wr(IDX_IRQ_STATUS, 8'h04);
        rd("irq_prog_clr", IDX_IRQ_STATUS, 8'h00);
        chk("fault_prog", 32'h0, {31'h0, flash_fault_flag});
        wr(IDX_MODE_CTRL, 8'h40);
        base = 17'h00000;
        for (int i = 0; i < 8; i++) begin
            size = (i < 4) ? 17'h00400 : (i == 4) ? 17'h07000 : 17'h08000;
            wr(IDX_BLOCK_SEL, 8'h01 << i);
            wr(IDX_MODE_CTRL, 8'h60);
            chk("valid", 32'h1, {31'h0, erase_window.valid});
            chk("index", i, {29'h0, erase_window.index});
            chk("base", {15'h0, base}, {15'h0, erase_window.base});
            chk("last", {15'h0, base + size - 17'h1}, {15'h0, erase_window.last});
            wr(IDX_BLOCK_SEL, 8'h00);
            rd("select_held", IDX_BLOCK_SEL, 8'h01 << i);
            if (i < 7) begin
                wr(IDX_MODE_CTRL, 8'h40);
            end
            base = base + size;
        end
        chk("top_end", 32'h0001FFFF, {15'h0, erase_window.last});
        wr(IDX_MODE_CTRL, 8'h62);
        rd("erase_run", IDX_MODE_CTRL, 8'hE2);
        chk("mode_out", 32'h000000E2, {24'h0, mode_out});
        rd("irq_status", IDX_IRQ_STATUS, 8'h02);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(IDX_MODE_CTRL, 8'h40);
        wr(IDX_BLOCK_SEL, 8'h03);
        wr(IDX_MODE_CTRL, 8'h60);
        chk("two_blocks", 32'h0, {31'h0, erase_window.valid});
        wr(IDX_MODE_CTRL, 8'h40);
        wr(IDX_IRQ_STATUS, 8'hFF);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_MODE_CTRL, 8'h42);
        rd("fault", IDX_ERR_STATUS, 8'h80);
        rd("mode_fault", IDX_MODE_CTRL, 8'hC0);
        chk("irq_fault", 32'h1, {31'h0, irq});
        wr(IDX_ERR_STATUS, 8'h00);
        rd("fault_ro", IDX_ERR_STATUS, 8'h80);
        wr(IDX_MODE_CTRL, 8'h50);
        rd("mode_held", IDX_MODE_CTRL, 8'hC0);
        wr(IDX_IRQ_STATUS, 8'h01);
        chk("irq_clear", 32'h0, {31'h0, irq});
        flash_write_gate_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd("gate_fell", IDX_IRQ_STATUS, 8'h08);
        wr(IDX_IRQ_MASK, 8'h09);
        chk("irq_gate", 32'h1, {31'h0, irq});
        reset_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd("fault_reset", IDX_ERR_STATUS, 8'h00);
        rd("irq_reset", IDX_IRQ_STATUS, 8'h00);
        chk("irq_off", 32'h0, {31'h0, irq});
        end_sim();
    end

endmodule : flcrm_tb_top
